// file: pkg/usp_pkg.sv
// Package for the serial port baud and shift-mode block.
// Assumes a 32-bit APB slave at 100 MHz and one clock domain.
package usp_pkg;
    // ***********************************************
    // Register offsets (byte addresses)
    // ***********************************************
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] BAUD_OFF = 8'h04;
    localparam logic [7:0] DATA_OFF = 8'h08;
    localparam logic [7:0] STAT_OFF = 8'h0c;
    localparam logic [7:0] MASK_OFF = 8'h10;
    // ***********************************************
    // Control field positions
    // ***********************************************
    localparam int MODE_LO_BIT = 0;
    localparam int MODE_HI_BIT = 1;
    localparam int RXEN_BIT = 2;
    localparam int DBL_BIT = 3;
    localparam int RCLK_BIT = 4;
    localparam int TX_CLOCK_SOURCE_SELECT_BIT = 5;
    localparam int CT_BIT = 6;
    localparam int TMODE_LSB = 8;
    // Status bits
    localparam int TXDONE_BIT = 0;
    localparam int RXDONE_BIT = 1;
    // ***********************************************
    // Rates and timing
    // ***********************************************
    localparam int OSC_PER_MC = 12;
    localparam int M2_DIV_SLOW = 64;
    localparam int M2_DIV_FAST = 32;
    localparam int T1_DIV = 32;
    localparam logic [8:0] T1_RANGE = 9'h100;
    localparam logic [1:0] T1_MODE_RELOAD = 2'h2;
    localparam logic [8:0] TX_MARK_LOAD = 9'h100;
    localparam logic [7:0] RX_INIT = 8'hfe;
    localparam logic [1:0] MODE0 = 2'h0;
    localparam logic [1:0] MODE1 = 2'h1;
    localparam logic [1:0] MODE2 = 2'h2;
    localparam logic [1:0] MODE3 = 2'h3;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SEND = 4'h2,
        ST_ARM = 4'h4,
        ST_RECV = 4'h8
    } usp_state_e;
endpackage

// file: verilog/usp_serial.sv
// Serial port: baud selection for all modes, mode 0 shift sequencing.
// Assumes APB master on pclk; timer 1 reload/overflow counted here.
// Contract
// - Mode 0 rate is oscillator over twelve
// - Mode 2 divides by 64 or 32
// - Modes 1 and 3 use timer overflow
// - Timer 1 rate times doubling over 32
// - Timer 1 works as timer or counter
// - Auto-reload rate uses 256 minus reload
// - Buffer write loads marker, requests send
// - Sending starts next machine cycle
// - Send routes data and strobe to pins
// - Each strobe shifts right, zeros in
// - Marker seen: last shift, done flag
// - Receive starts when enabled, flag clear
// - Load 11111110, then receive active
// - Strobe shifts left, samples input pin
// - Zero at top: shift, load, flag
// - Two select bits choose mode
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module usp_serial #(
    parameter int OSC_DIV = usp_pkg::OSC_PER_MC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic t1_count_in,
    input wire logic t2_overflow,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd_out,
    output logic baud_tick,
    output logic irq
);
    // ***********************************************
    // Bus decode
    // ***********************************************
    wire logic acc = psel & penable;
    wire logic wr = acc & pwrite;
    wire logic wr_ctrl = wr && paddr == usp_pkg::CTRL_OFF;
    wire logic wr_baud = wr && paddr == usp_pkg::BAUD_OFF;
    wire logic wr_data = wr && paddr == usp_pkg::DATA_OFF;
    wire logic wr_stat = wr && paddr == usp_pkg::STAT_OFF;
    wire logic wr_mask = wr && paddr == usp_pkg::MASK_OFF;
    wire logic mapped = paddr == usp_pkg::CTRL_OFF || paddr == usp_pkg::BAUD_OFF
        || paddr == usp_pkg::DATA_OFF || paddr == usp_pkg::STAT_OFF || paddr == usp_pkg::MASK_OFF;

    logic [9:0] ctrl_reg;
    logic [7:0] timer1_reload_byte;
    logic [7:0] serial_data_buffer;
    logic [1:0] stat_reg;
    logic [1:0] mask_reg;
    logic [7:0] rdata_next;

    // Single-cycle access, error on unmapped offsets
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;

    // Read data mux
    always_comb begin
        case (paddr)
            usp_pkg::CTRL_OFF: rdata_next = ctrl_reg[7:0];
            usp_pkg::BAUD_OFF: rdata_next = timer1_reload_byte;
            usp_pkg::DATA_OFF: rdata_next = serial_data_buffer;
            usp_pkg::STAT_OFF: rdata_next = {6'h00, stat_reg};
            usp_pkg::MASK_OFF: rdata_next = {6'h00, mask_reg};
            default: rdata_next = 8'h00;
        endcase
    end
    wire logic [31:0] rd_word = (paddr == usp_pkg::CTRL_OFF) ? {22'h000000, ctrl_reg} : {24'h000000, rdata_next};
    assign prdata = (acc & ~pwrite) ? rd_word : 32'h00000000;

    // ***********************************************
    // Control fields
    // ***********************************************
    wire logic mode_select_low = ctrl_reg[usp_pkg::MODE_LO_BIT];
    wire logic mode_select_high = ctrl_reg[usp_pkg::MODE_HI_BIT];
    wire logic [1:0] mode = {mode_select_high, mode_select_low};
    wire logic rx_enable = ctrl_reg[usp_pkg::RXEN_BIT];
    wire logic double_rate_select = ctrl_reg[usp_pkg::DBL_BIT];
    wire logic rx_clock_source_select = ctrl_reg[usp_pkg::RCLK_BIT];
    wire logic tx_clock_source_select = ctrl_reg[usp_pkg::TX_CLOCK_SOURCE_SELECT_BIT];
    wire logic t1_counter_sel = ctrl_reg[usp_pkg::CT_BIT];
    wire logic [1:0] t1_mode = ctrl_reg[usp_pkg::TMODE_LSB +: 2];

    // Control and reload registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 10'h000;
            timer1_reload_byte <= 8'h00;
            mask_reg <= 2'h0;
        end else begin
            if (wr_ctrl) ctrl_reg <= pwdata[9:0];
            if (wr_baud) timer1_reload_byte <= pwdata[7:0];
            if (wr_mask) mask_reg <= pwdata[1:0];
        end
    end

    // ***********************************************
    // Machine cycle divider
    // ***********************************************
    logic [3:0] osc_cnt;
    wire logic mc_tick = osc_cnt == 4'(OSC_DIV - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) osc_cnt <= 4'h0;
        else osc_cnt <= mc_tick ? 4'h0 : osc_cnt + 4'h1;
    end

    // ***********************************************
    // Timer 1: timer or counter, modes 0..2
    // ***********************************************
    logic [15:0] t1_cnt;
    logic t1_cin_d;
    wire logic t1_inc = t1_counter_sel ? (t1_count_in & ~t1_cin_d) : mc_tick;
    wire logic t1_ovf_m0 = t1_inc && t1_cnt[12:0] == 13'h1fff;
    wire logic t1_ovf_m1 = t1_inc && t1_cnt == 16'hffff;
    wire logic t1_ovf_m2 = t1_inc && t1_cnt[7:0] == 8'hff;
    wire logic t1_ovf = (t1_mode == 2'h0) ? t1_ovf_m0 : (t1_mode == 2'h1) ? t1_ovf_m1 : t1_ovf_m2;
    // Counter update per mode; reload mode restarts from reload byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_cnt <= 16'h0000;
            t1_cin_d <= 1'b0;
        end else begin
            t1_cin_d <= t1_count_in;
            if (t1_inc) begin
                if (t1_mode == usp_pkg::T1_MODE_RELOAD && t1_ovf_m2)
                    t1_cnt <= {8'h00, timer1_reload_byte};
                else
                    t1_cnt <= t1_cnt + 16'h0001;
            end
        end
    end

    // ***********************************************
    // Baud tick: per-mode divider of the source
    // ***********************************************
    wire logic use_t2 = rx_clock_source_select | tx_clock_source_select;
    wire logic src_ovf = use_t2 ? t2_overflow : t1_ovf;
    logic [5:0] bdiv;
    logic [5:0] osc_div;
    wire logic [5:0] var_lim = double_rate_select ? 6'(usp_pkg::T1_DIV / 2 - 1) : 6'(usp_pkg::T1_DIV - 1);
    wire logic [5:0] m2_lim = double_rate_select ? 6'(usp_pkg::M2_DIV_FAST - 1) : 6'(usp_pkg::M2_DIV_SLOW - 1);
    wire logic var_tick = src_ovf && bdiv == var_lim;
    wire logic m2_tick = osc_div == m2_lim;
    // Selected bit-rate pulse
    always_comb begin
        case (mode)
            usp_pkg::MODE0: baud_tick = mc_tick;
            usp_pkg::MODE2: baud_tick = m2_tick;
            default: baud_tick = var_tick;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bdiv <= 6'h00;
            osc_div <= 6'h00;
        end else begin
            if (src_ovf) bdiv <= var_tick ? 6'h00 : bdiv + 6'h01;
            osc_div <= m2_tick ? 6'h00 : osc_div + 6'h01;
        end
    end

    // ***********************************************
    // Mode 0 shift sequencer
    // ***********************************************
    usp_pkg::usp_state_e state_reg, state_next;
    logic [8:0] tx_sh;
    logic [7:0] rx_sh;
    logic tx_req;
    wire logic m0 = mode == usp_pkg::MODE0;
    wire logic send_act = state_reg == usp_pkg::ST_SEND;
    wire logic recv_act = state_reg == usp_pkg::ST_RECV;
    wire logic tx_last = tx_sh[8:1] == 8'h01;
    wire logic rx_last = ~rx_sh[7];
    wire logic rx_cond = m0 & rx_enable & ~stat_reg[usp_pkg::RXDONE_BIT];

    // Next state
    always_comb begin
        case (state_reg)
            usp_pkg::ST_IDLE: begin
                if (m0 && tx_req && mc_tick) state_next = usp_pkg::ST_SEND;
                else if (rx_cond && mc_tick) state_next = usp_pkg::ST_ARM;
                else state_next = usp_pkg::ST_IDLE;
            end
            usp_pkg::ST_SEND: state_next = (mc_tick && tx_last) ? usp_pkg::ST_IDLE : usp_pkg::ST_SEND;
            usp_pkg::ST_ARM: state_next = usp_pkg::ST_RECV;
            usp_pkg::ST_RECV: state_next = (mc_tick && rx_last) ? usp_pkg::ST_IDLE : usp_pkg::ST_RECV;
            default: state_next = usp_pkg::ST_IDLE;
        endcase
    end

    // Strobe low for first half of each machine cycle
    wire logic strobe = osc_cnt >= 4'(OSC_DIV / 2);
    assign txd_out = (send_act | recv_act) ? strobe : 1'b1;
    assign rxd_out = tx_sh[0];
    assign rxd_oe = send_act;

    wire logic tx_done_set = send_act & mc_tick & tx_last;
    wire logic rx_done_set = recv_act & mc_tick & rx_last;

    // Shift registers, buffer and sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= usp_pkg::ST_IDLE;
            tx_sh <= 9'h000;
            rx_sh <= 8'hff;
            tx_req <= 1'b0;
            serial_data_buffer <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (wr_data) begin
                tx_sh <= usp_pkg::TX_MARK_LOAD | {1'b0, pwdata[7:0]};
                tx_req <= 1'b1;
            end else if (send_act && mc_tick) begin
                tx_sh <= {1'b0, tx_sh[8:1]};
                tx_req <= 1'b0;
            end
            if (state_reg == usp_pkg::ST_ARM) rx_sh <= usp_pkg::RX_INIT;
            else if (recv_act && mc_tick) rx_sh <= {rx_sh[6:0], rxd_in};
            if (rx_done_set) serial_data_buffer <= {rx_sh[6:0], rxd_in};
        end
    end

    // ***********************************************
    // Sticky flags, mask, interrupt
    // ***********************************************
    wire logic [1:0] set_vec = {rx_done_set, tx_done_set};
    wire logic [1:0] clr_vec = wr_stat ? pwdata[1:0] : 2'h0;
    // Set beats clear; only software clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) stat_reg <= 2'h0;
        else stat_reg <= set_vec | (stat_reg & ~clr_vec);
    end
    assign irq = |(stat_reg & mask_reg);

    // ***********************************************
    // Checks
    // ***********************************************
    // ***********************************************
    // Check helpers: gap and frame counters
    // ***********************************************
    // Clocks since the last machine-cycle end, held at its top
    logic [3:0] mc_gap;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mc_gap <= 4'h0;
        else if (mc_tick) mc_gap <= 4'h0;
        else if (mc_gap != 4'hf) mc_gap <= mc_gap + 4'h1;
    end
    // Strobes counted per frame, checked at the last shift
    logic [3:0] tx_bits;
    logic [3:0] rx_bits;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_bits <= 4'h0;
            rx_bits <= 4'h0;
        end else begin
            if (!send_act) tx_bits <= 4'h0;
            else if (mc_tick) tx_bits <= tx_bits + 4'h1;
            if (!recv_act) rx_bits <= 4'h0;
            else if (mc_tick) rx_bits <= rx_bits + 4'h1;
        end
    end
    property p_mc_period;
        @(posedge pclk) disable iff (!presetn) mc_tick |-> ##12 (mc_tick && mc_gap == 4'hb);
    endproperty
    a_mc_period: assert property (p_mc_period) else $error("machine cycle not twelve clocks");
    property p_m2_rate;
        @(posedge pclk) disable iff (!presetn)
            (m2_tick && !double_rate_select && !wr_ctrl) |=> !m2_tick [*8];
    endproperty
    a_m2_rate: assert property (p_m2_rate) else $error("mode 2 tick too soon");
    property p_t1_reload;
        @(posedge pclk) disable iff (!presetn)
            (t1_mode == 2'h2 && t1_ovf_m2 && !wr_ctrl) |=> t1_cnt[7:0] == $past(timer1_reload_byte);
    endproperty
    a_t1_reload: assert property (p_t1_reload) else $error("reload byte not loaded");
    property p_tx_load;
        @(posedge pclk) disable iff (!presetn) wr_data |=> tx_sh[8] && tx_req;
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("marker not loaded");
    property p_send_route;
        @(posedge pclk) disable iff (!presetn) send_act |-> rxd_oe && rxd_out == tx_sh[0];
    endproperty
    a_send_route: assert property (p_send_route) else $error("send routing wrong");
    property p_tx_shift;
        @(posedge pclk) disable iff (!presetn)
            (send_act && mc_tick && !wr_data) |=> tx_sh == {1'b0, $past(tx_sh[8:1])};
    endproperty
    a_tx_shift: assert property (p_tx_shift) else $error("transmit shift wrong");
    property p_tx_done;
        @(posedge pclk) disable iff (!presetn) tx_done_set |=> stat_reg[0] && !send_act;
    endproperty
    a_tx_done: assert property (p_tx_done) else $error("transmit end wrong");
    sequence s_arm;
        state_reg == usp_pkg::ST_ARM;
    endsequence
    property p_rx_arm;
        @(posedge pclk) disable iff (!presetn) s_arm |=> rx_sh == 8'hfe ##0 recv_act;
    endproperty
    a_rx_arm: assert property (p_rx_arm) else $error("receive arm wrong");
    property p_rx_done;
        @(posedge pclk) disable iff (!presetn)
            rx_done_set |=> stat_reg[1] && !recv_act && serial_data_buffer == $past({rx_sh[6:0], rxd_in});
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("receive end wrong");
    property p_flag_hold;
        @(posedge pclk) disable iff (!presetn) (stat_reg[0] && !wr_stat) |=> stat_reg[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware");

    // ***********************************************
    // Sequencer, pin and rate source checks
    // ***********************************************
    sequence s_tx_go;
        state_reg == usp_pkg::ST_IDLE && m0 && tx_req && mc_tick;
    endsequence
    property p_tx_start;
        @(posedge pclk) disable iff (!presetn) s_tx_go |=> send_act && rxd_oe;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("send did not start");
    sequence s_rx_go;
        state_reg == usp_pkg::ST_IDLE && !(m0 && tx_req) && rx_cond && mc_tick;
    endsequence
    property p_rx_start;
        @(posedge pclk) disable iff (!presetn) s_rx_go |=> s_arm ##1 recv_act;
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("receive did not start");
    // One strobe per machine cycle while a frame runs
    property p_strobe_cycle;
        @(posedge pclk) disable iff (!presetn)
            (mc_tick && ((send_act && !tx_last) || (recv_act && !rx_last))) |=> !txd_out ##6 txd_out;
    endproperty
    a_strobe_cycle: assert property (p_strobe_cycle) else $error("shift strobe shape wrong");
    property p_idle_pins;
        @(posedge pclk) disable iff (!presetn) (!send_act && !recv_act) |-> txd_out && !rxd_oe;
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("pins active outside a frame");
    property p_tx_hold;
        @(posedge pclk) disable iff (!presetn) (send_act && !mc_tick && !wr_data) |=> $stable(tx_sh);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit moved between strobes");
    property p_tx_count;
        @(posedge pclk) disable iff (!presetn) tx_done_set |-> tx_bits == 4'h7;
    endproperty
    a_tx_count: assert property (p_tx_count) else $error("send length wrong");
    property p_rx_shift;
        @(posedge pclk) disable iff (!presetn)
            (recv_act && mc_tick) |=> rx_sh == {$past(rx_sh[6:0]), $past(rxd_in)};
    endproperty
    a_rx_shift: assert property (p_rx_shift) else $error("receive shift wrong");
    property p_rx_count;
        @(posedge pclk) disable iff (!presetn) rx_done_set |-> rx_bits == 4'h7;
    endproperty
    a_rx_count: assert property (p_rx_count) else $error("receive length wrong");
    property p_t1_source;
        @(posedge pclk) disable iff (!presetn) (baud_tick && mode == usp_pkg::MODE1 && !use_t2) |-> t1_ovf;
    endproperty
    a_t1_source: assert property (p_t1_source) else $error("rate tick without timer 1 overflow");
    property p_t2_source;
        @(posedge pclk) disable iff (!presetn) (baud_tick && mode[0] && use_t2) |-> t2_overflow;
    endproperty
    a_t2_source: assert property (p_t2_source) else $error("rate tick without timer 2 overflow");
    property p_refused;
        @(posedge pclk) disable iff (!presetn) (acc && !mapped) |-> pslverr && prdata == 32'h00000000;
    endproperty
    a_refused: assert property (p_refused) else $error("unmapped access not refused");
endmodule
`default_nettype wire

// file: testbench/usp_shift_partner.sv
// External shift register on the mode 0 serial pins.
// Assumes strobe high when idle and data pin resolved by the bench.
`timescale 1ns/1ns
`default_nettype none
module usp_shift_partner (
    input wire logic pclk,
    input wire logic strobe,
    input wire logic oe,
    input wire logic pin,
    input wire logic arm,
    input wire logic [7:0] rx_byte,
    output logic drv,
    output logic [8:0] cap,
    output logic [7:0] tx_cnt,
    output logic [7:0] rx_cnt
);
    logic strb_q = 1'b1;
    logic [3:0] idx = 4'h8;
    initial drv = 1'b0;
    initial cap = 9'h000;
    initial tx_cnt = 8'h00;
    initial rx_cnt = 8'h00;
    // Capture on strobe rise, feed bits when receiving, toggle when released
    always @(posedge pclk) begin
        strb_q <= strobe;
        if (arm) begin
            idx <= 4'h0;
        end else if (strobe && !strb_q) begin
            if (oe) begin
                cap <= {pin, cap[8:1]};
                tx_cnt <= tx_cnt + 8'h01;
            end else begin
                rx_cnt <= rx_cnt + 8'h01;
                if (idx < 4'h8) begin
                    drv <= rx_byte[3'h7 - idx[2:0]];
                    idx <= idx + 4'h1;
                end
            end
        end else if (idx == 4'h8) begin
            drv <= ~drv;
        end
    end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Testbench for the serial port block: APB tasks and directed tests.
// Assumes a zero-wait APB slave and the shift register partner model.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // ***********************************************
    // Signals, design and partner
    // ***********************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic t1_count_in = 1'b0;
    logic t2_overflow = 1'b0;
    logic arm = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [31:0] prdata, rv;
    logic pready, pslverr, rxd_out, rxd_oe, txd_out, baud_tick, irq, drv, ev;
    logic [8:0] cap;
    logic [7:0] tx_cnt, rx_cnt;
    wire logic rxd_in;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int ph = 0;
    int n;
    logic [31:0] ctab [8] = '{32'h0, 32'h8, 32'h2, 32'ha, 32'h201, 32'h209, 32'h249, 32'h3b};
    logic [31:0] btab [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hff, 32'hfe, 32'hff, 32'h0};
    int etab [8] = '{usp_pkg::OSC_PER_MC, usp_pkg::OSC_PER_MC, usp_pkg::M2_DIV_SLOW, usp_pkg::M2_DIV_FAST,
        usp_pkg::OSC_PER_MC * 1 * usp_pkg::T1_DIV, usp_pkg::OSC_PER_MC * 2 * usp_pkg::T1_DIV / 2,
        8 * usp_pkg::T1_DIV / 2, 10 * usp_pkg::T1_DIV / 2};
    // Data pin resolved from both parties
    assign rxd_in = rxd_oe ? rxd_out : drv;
    usp_serial #(.OSC_DIV(usp_pkg::OSC_PER_MC)) i_usp_serial (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .t1_count_in(t1_count_in), .t2_overflow(t2_overflow), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .baud_tick(baud_tick), .irq(irq));
    usp_shift_partner i_usp_shift_partner (.pclk(pclk), .strobe(txd_out), .oe(rxd_oe), .pin(rxd_in),
        .arm(arm), .rx_byte(rx_byte), .drv(drv), .cap(cap), .tx_cnt(tx_cnt), .rx_cnt(rx_cnt));
    // ***********************************************
    // Clock, timer inputs and timeout
    // ***********************************************
    always #5 pclk = ~pclk;
    // Event input period 8 clocks, overflow pulse every 10 clocks
    always @(posedge pclk) begin
        ph <= (ph == 39) ? 0 : ph + 1;
        t1_count_in <= (ph % 8) >= 4;
        t2_overflow <= (ph % 10) == 0;
    end
    // Cut a hang short
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            test_done();
        end
    end
    // ***********************************************
    // Tasks
    // ***********************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_stat(input logic [31:0] m);
        for (int k = 0; k < 100; k++) begin
            apb(1'b0, usp_pkg::STAT_OFF, 32'h0, rv, ev);
            if ((rv & m) !== 32'h0) break;
        end
    endtask
    // Interval between rate ticks after settling
    task automatic measure(input logic [31:0] c, input logic [31:0] b, input int e);
        apb(1'b1, usp_pkg::BAUD_OFF, b, rv, ev);
        apb(1'b1, usp_pkg::CTRL_OFF, c, rv, ev);
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (baud_tick !== 1'b1 && n < 3000);
        end
        chk(n, e);
    endtask
    // ***********************************************
    // Main sequence
    // ***********************************************
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, usp_pkg::STAT_OFF, 32'h0, rv, ev);
        chk(rv, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h40, 32'h0, rv, ev);
        chk({31'h0, ev}, 32'h1);
        chk(rv, 32'h0);
        // Rates of all four modes; timer overflow cases with no timer interrupt in play
        for (int i = 0; i < 8; i++) measure(ctab[i], btab[i], etab[i]);
        // Mode 0 send
        apb(1'b1, usp_pkg::CTRL_OFF, 32'h0, rv, ev);
        apb(1'b1, usp_pkg::MASK_OFF, 32'h3, rv, ev);
        apb(1'b1, usp_pkg::DATA_OFF, 32'ha5, rv, ev);
        n = 0;
        while (rxd_oe !== 1'b1 && n < 30) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, n < 24}, 32'h1);
        wait_stat(32'h1);
        chk(rv, 32'h1);
        chk({24'h0, cap[8:1]}, 32'ha5);
        chk({31'h0, rxd_out}, 32'h1);
        chk({24'h0, tx_cnt}, 32'h8);
        chk({30'h0, rxd_oe, irq}, 32'h1);
        apb(1'b1, usp_pkg::MASK_OFF, 32'h0, rv, ev);
        chk({31'h0, irq}, 32'h0);
        repeat (50) @(posedge pclk);
        apb(1'b1, usp_pkg::MASK_OFF, 32'h3, rv, ev);
        apb(1'b0, usp_pkg::STAT_OFF, 32'h0, rv, ev);
        chk({rv[30:0], irq}, 32'h3);
        apb(1'b1, usp_pkg::STAT_OFF, 32'h1, rv, ev);
        apb(1'b0, usp_pkg::STAT_OFF, 32'h0, rv, ev);
        chk({rv[30:0], irq}, 32'h0);
        // Mode 0 receive
        rx_byte <= 8'h4d;
        arm <= 1'b1;
        @(posedge pclk);
        arm <= 1'b0;
        apb(1'b1, usp_pkg::CTRL_OFF, 32'h4, rv, ev);
        wait_stat(32'h2);
        chk({rv[30:0], irq}, 32'h5);
        apb(1'b0, usp_pkg::DATA_OFF, 32'h0, rv, ev);
        chk(rv, 32'h4d);
        repeat (60) @(posedge pclk);
        chk({24'h0, rx_cnt}, 32'h8);
        apb(1'b1, usp_pkg::CTRL_OFF, 32'h0, rv, ev);
        apb(1'b1, usp_pkg::STAT_OFF, 32'h2, rv, ev);
        apb(1'b0, usp_pkg::STAT_OFF, 32'h0, rv, ev);
        chk(rv, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
